// ---- verilog/ssp_strap_status.sv ----
/*
 * strap sampling and status pin logic: samples the configuration pins
 * at reset release, then turns the bus mode pin, and in smbus mode the three billboard pins, into upstream link indicators.
 * assumes pins pass through pads giving input, output and enable, and
 * that host register writes arrive as one-cycle strobes on ref_clk.
 */
// Functional notes
// - latch bus mode strap at reset release
// - bus mode pin shows superspeed suspend
// - latch polarity; drive four power outputs
// - i2c mode: billboard follows enable pin
// - smbus mode: billboard enable from register
// - smbus: enable pin shows high-speed connect
// - smbus: latch grouped power, host overrides
// - i2c: configured field from two pins
// - smbus: configured field from register
// - smbus charging: bit0 pin sets full auto
// - smbus no charging: bit0 sets switch support
// - smbus: bit0 pin shows superspeed connect
// - smbus: bit1 pin sets auto charge mode
// - smbus: bit1 pin shows high-speed suspend
// - smbus mode: serial pins act as target
`timescale 1ns/10ps
module ssp_strap_status #(
    parameter int NUM_PORTS = ssp_pkg::NUM_PORTS
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic bus_mode_strap_in,
    output logic bus_mode_strap_out,
    output logic bus_mode_strap_oe,
    input wire logic power_control_polarity_strap,
    input wire logic billboard_enable_pin_in,
    output logic billboard_enable_pin_out,
    output logic billboard_enable_pin_oe,
    input wire logic billboard_config_bit0_pin_in,
    output logic billboard_config_bit0_pin_out,
    output logic billboard_config_bit0_pin_oe,
    input wire logic billboard_config_bit1_pin_in,
    output logic billboard_config_bit1_pin_out,
    output logic billboard_config_bit1_pin_oe,
    input wire logic status_output_enable,
    input wire logic charging_enabled,
    input wire logic [NUM_PORTS-1:0] port_power_on,
    input wire ssp_pkg::ssp_link_t link_status,
    input wire logic reg_billboard_enable,
    input wire logic [1:0] reg_billboard_configured,
    input wire ssp_pkg::ssp_host_wr_t host_wr,
    output logic [NUM_PORTS-1:0] port_power_control_outputs,
    output logic smbus_target_mode,
    output logic billboard_present,
    output logic [1:0] billboard_configured_field,
    output logic grouped_power,
    output logic full_auto_charge_enable,
    output logic power_switch_unsupported,
    output logic auto_charge_mode_bit
);

    // ------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------
    logic [4:0] pin_s1_q;               // first stage, read by second only
    logic [4:0] pin_s2_q;               // synchronised pin levels
    ssp_pkg::ssp_straps_t pins;         // named view of synced pins
    ssp_pkg::ssp_straps_t straps_q;     // latched strap levels
    logic rst_d1_q;                     // reset delayed one cycle
    logic sample;                       // first cycle after reset release
    logic smbus;                        // smbus mode selected
    logic drive_sts;                    // indicators enabled

    // two flops on every pin input before any logic
    always_ff @(posedge ref_clk) begin
        pin_s1_q <= {billboard_config_bit1_pin_in, billboard_config_bit0_pin_in,
                     billboard_enable_pin_in, power_control_polarity_strap,
                     bus_mode_strap_in};
        pin_s2_q <= pin_s1_q;
    end

    assign pins = ssp_pkg::ssp_straps_t'(pin_s2_q);

    // ------------------------------------------------------------
    // strap latch
    // ------------------------------------------------------------
    // remembers reset so the release edge can be seen
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            rst_d1_q <= 1'b1;
        end else begin
            rst_d1_q <= 1'b0;
        end
    end

    assign sample = rst_d1_q && !srst;

    // straps caught once at release, then held until reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            straps_q <= '{cfg1: ssp_pkg::RST_LOW_STRAP, cfg0: ssp_pkg::RST_LOW_STRAP,
                          bb_en: ssp_pkg::RST_LOW_STRAP,
                          polarity: ssp_pkg::RST_POLARITY,
                          bus_mode: ssp_pkg::RST_BUS_MODE};
        end else if (sample) begin
            straps_q <= pins;
        end
    end

    assign smbus = (straps_q.bus_mode == ssp_pkg::BUS_MODE_SMBUS);
    assign drive_sts = status_output_enable && !rst_d1_q;

    // ------------------------------------------------------------
    // mode and power outputs
    // ------------------------------------------------------------
    // serial pins as smbus target when strap read low
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            smbus_target_mode <= 1'b0;
        end else begin
            smbus_target_mode <= smbus;
        end
    end

    // power control outputs with latched polarity; all off in reset
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            port_power_control_outputs <= '0;
        end else if (straps_q.polarity == ssp_pkg::POL_ACTIVE_HIGH) begin
            port_power_control_outputs <= port_power_on;
        end else begin
            port_power_control_outputs <= ~port_power_on;
        end
    end

    // ------------------------------------------------------------
    // billboard selection
    // ------------------------------------------------------------
    // pin in i2c mode, register in smbus mode
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            billboard_present <= 1'b0;
            billboard_configured_field <= 2'h0;
        end else if (smbus) begin
            billboard_present <= reg_billboard_enable;
            billboard_configured_field <= reg_billboard_configured;
        end else begin
            billboard_present <= pins.bb_en;
            billboard_configured_field <= {pins.cfg1, pins.cfg0};
        end
    end

    // ------------------------------------------------------------
    // configuration bits: strap seeds, host write overrides
    // ------------------------------------------------------------
    // grouped power
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            grouped_power <= 1'b0;
        end else if (sample && pins.bus_mode == ssp_pkg::BUS_MODE_SMBUS) begin
            grouped_power <= pins.bb_en;
        end else if (smbus && host_wr.wr_grouped) begin
            grouped_power <= host_wr.grouped;
        end
    end

    // full auto charge enable, only seeded with charging on
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            full_auto_charge_enable <= 1'b0;
        end else if (sample && pins.bus_mode == ssp_pkg::BUS_MODE_SMBUS
                     && charging_enabled) begin
            full_auto_charge_enable <= pins.cfg0;
        end else if (smbus && host_wr.wr_full_auto) begin
            full_auto_charge_enable <= host_wr.full_auto;
        end
    end

    // power switch support, only seeded with charging off
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            power_switch_unsupported <= 1'b0;
        end else if (sample && pins.bus_mode == ssp_pkg::BUS_MODE_SMBUS
                     && !charging_enabled) begin
            power_switch_unsupported <= pins.cfg0;
        end else if (smbus && host_wr.wr_no_switch) begin
            power_switch_unsupported <= host_wr.no_switch;
        end
    end

    // auto charge mode bit
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            auto_charge_mode_bit <= 1'b0;
        end else if (sample && pins.bus_mode == ssp_pkg::BUS_MODE_SMBUS) begin
            auto_charge_mode_bit <= pins.cfg1;
        end else if (smbus && host_wr.wr_auto_mode) begin
            auto_charge_mode_bit <= host_wr.auto_mode;
        end
    end

    // ------------------------------------------------------------
    // status indicators
    // ------------------------------------------------------------
    // pins driven only after reset with indicators enabled
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            bus_mode_strap_oe <= 1'b0;
            bus_mode_strap_out <= 1'b0;
            billboard_enable_pin_oe <= 1'b0;
            billboard_enable_pin_out <= 1'b0;
            billboard_config_bit0_pin_oe <= 1'b0;
            billboard_config_bit0_pin_out <= 1'b0;
            billboard_config_bit1_pin_oe <= 1'b0;
            billboard_config_bit1_pin_out <= 1'b0;
        end else begin
            bus_mode_strap_oe <= drive_sts;
            bus_mode_strap_out <= link_status.ss_suspend;
            billboard_enable_pin_oe <= drive_sts && smbus;
            billboard_enable_pin_out <= link_status.hs_connect;
            billboard_config_bit0_pin_oe <= drive_sts && smbus;
            billboard_config_bit0_pin_out <= link_status.ss_connect;
            billboard_config_bit1_pin_oe <= drive_sts && smbus;
            billboard_config_bit1_pin_out <= link_status.high_speed_suspend_indicator;
        end
    end

endmodule

// ---- verilog/ssp_pkg.sv ----
/*
 * package for the strap sampling and status pin block: strap field
 * layout, reset values and mode encodings.
 * assumes one clock domain; used as ssp_pkg::name with no import.
 */
package ssp_pkg;

    // ------------------------------------------------------------
    // counts and encodings
    // ------------------------------------------------------------
    localparam int NUM_PORTS = 4;               // port power-control outputs
    localparam logic BUS_MODE_I2C = 1'b1;       // strap level for i2c mode
    localparam logic BUS_MODE_SMBUS = 1'b0;     // strap level for smbus mode
    localparam logic POL_ACTIVE_HIGH = 1'b1;    // polarity strap level

    // ------------------------------------------------------------
    // reset values of latched straps
    // ------------------------------------------------------------
    localparam logic RST_BUS_MODE = 1'b1;       // pull-up default
    localparam logic RST_POLARITY = 1'b1;       // pull-up default
    localparam logic RST_LOW_STRAP = 1'b0;      // pull-down default

    // ------------------------------------------------------------
    // field positions in the latched strap word
    // ------------------------------------------------------------
    localparam int BIT_BUS_MODE = 0;
    localparam int BIT_POLARITY = 1;
    localparam int BIT_BB_EN = 2;
    localparam int BIT_CFG0 = 3;
    localparam int BIT_CFG1 = 4;

    // latched strap levels
    typedef struct packed {
        logic cfg1;         // billboard config bit 1 pin
        logic cfg0;         // billboard config bit 0 pin
        logic bb_en;        // billboard enable / grouped power pin
        logic polarity;     // power control polarity strap
        logic bus_mode;     // bus mode strap
    } ssp_straps_t;

    // upstream link status fed to the indicators
    typedef struct packed {
        logic ss_suspend;   // superspeed link suspended
        logic high_speed_suspend_indicator;   // high-speed link suspended
        logic ss_connect;   // attached to superspeed port
        logic hs_connect;   // attached to high-speed port
    } ssp_link_t;

    // host register overrides in smbus mode
    typedef struct packed {
        logic wr_grouped;       // write strobe for grouped power
        logic grouped;
        logic wr_full_auto;     // write strobe for full auto enable
        logic full_auto;
        logic wr_no_switch;     // write strobe for power switch support
        logic no_switch;
        logic wr_auto_mode;     // write strobe for auto charge mode
        logic auto_mode;
    } ssp_host_wr_t;

endpackage

// ---- tb/ssp_strap_status_assertions.sv ----
/* port checker for the strap sampling block.
   assumes one clock, srst synchronous active high. */
`timescale 1ns/10ps
module ssp_strap_status_assertions #(
    parameter int NUM_PORTS = ssp_pkg::NUM_PORTS
) (
    input wire logic ref_clk,
    input wire logic srst,
    input wire logic bus_mode_strap_out,
    input wire logic bus_mode_strap_oe,
    input wire logic billboard_enable_pin_in,
    input wire logic billboard_enable_pin_out,
    input wire logic billboard_enable_pin_oe,
    input wire logic billboard_config_bit0_pin_out,
    input wire logic billboard_config_bit0_pin_oe,
    input wire logic billboard_config_bit1_pin_out,
    input wire logic billboard_config_bit1_pin_oe,
    input wire logic status_output_enable,
    input wire logic [NUM_PORTS-1:0] port_power_on,
    input wire ssp_pkg::ssp_link_t link_status,
    input wire logic reg_billboard_enable,
    input wire ssp_pkg::ssp_host_wr_t host_wr,
    input wire logic [NUM_PORTS-1:0] port_power_control_outputs,
    input wire logic smbus_target_mode,
    input wire logic billboard_present,
    input wire logic grouped_power
);
    // ------------------------------------------------------------
    // cycles since release, saturating at 3
    // ------------------------------------------------------------
    logic [1:0] run_q;
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            run_q <= 2'h0;
        end else if (run_q != 2'h3) begin
            run_q <= run_q + 2'h1;
        end
    end
    wire up = (run_q == 2'h3);
    wire sm = up && smbus_target_mode && status_output_enable;
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (srst);
    property p_quiet;
        disable iff (1'b0) srst |=> !bus_mode_strap_oe && !billboard_enable_pin_oe
            && !billboard_config_bit0_pin_oe && !billboard_config_bit1_pin_oe
            && port_power_control_outputs == '0 && !smbus_target_mode;
    endproperty
    a_quiet: assert property (p_quiet) else $error("output active in reset");
    property p_ss_susp;
        up && status_output_enable |=> bus_mode_strap_oe
            && bus_mode_strap_out == $past(link_status.ss_suspend);
    endproperty
    a_ss_susp: assert property (p_ss_susp) else $error("ss suspend pin wrong");
    property p_high_speed_upstream_indicator;
        sm |=> billboard_enable_pin_oe
            && billboard_enable_pin_out == $past(link_status.hs_connect);
    endproperty
    a_high_speed_upstream_indicator: assert property (p_high_speed_upstream_indicator) else $error("hs connect pin wrong");
    property p_ss_up;
        sm |=> billboard_config_bit0_pin_oe
            && billboard_config_bit0_pin_out == $past(link_status.ss_connect);
    endproperty
    a_ss_up: assert property (p_ss_up) else $error("ss connect pin wrong");
    property p_hs_susp;
        sm |=> billboard_config_bit1_pin_oe
            && billboard_config_bit1_pin_out == $past(link_status.high_speed_suspend_indicator);
    endproperty
    a_hs_susp: assert property (p_hs_susp) else $error("high_speed_suspend_indicator pin wrong");
    property p_pwr;
        up |=> (port_power_control_outputs ^ $past(port_power_on)) == '0
            || (port_power_control_outputs ^ $past(port_power_on)) == '1;
    endproperty
    a_pwr: assert property (p_pwr) else $error("power outputs mixed");
    property p_hold;
        up |=> $stable(smbus_target_mode);
    endproperty
    a_hold: assert property (p_hold) else $error("bus mode moved");
    property p_bb_i2c;
        (up && !smbus_target_mode && $stable(billboard_enable_pin_in))[*4]
            |-> billboard_present == billboard_enable_pin_in;
    endproperty
    a_bb_i2c: assert property (p_bb_i2c) else $error("billboard not from pin");
    property p_bb_sm;
        (up && smbus_target_mode && $stable(reg_billboard_enable))[*3]
            |-> billboard_present == reg_billboard_enable;
    endproperty
    a_bb_sm: assert property (p_bb_sm) else $error("billboard not from reg");
    property p_grp;
        up && smbus_target_mode && host_wr.wr_grouped |=> grouped_power == $past(host_wr.grouped);
    endproperty
    a_grp: assert property (p_grp) else $error("grouped write lost");
    c_i2c: cover property (up && !smbus_target_mode);
    c_wr: cover property (up && smbus_target_mode && host_wr.wr_grouped);
    c_ind: cover property (sm);
endmodule
bind ssp_strap_status ssp_strap_status_assertions #(.NUM_PORTS(NUM_PORTS)) ssp_chk_inst (.*);

// ---- tb/ssp_board_model.sv ----
/* board strap resistors on the shared pins: an undriven pin sits at
   its resistor level. assumes the bench sets straps before release. */
`timescale 1ns/10ps
module ssp_board_model (
    input wire ssp_pkg::ssp_straps_t straps,
    input wire logic bus_mode_strap_out,
    input wire logic bus_mode_strap_oe,
    input wire logic billboard_enable_pin_out,
    input wire logic billboard_enable_pin_oe,
    input wire logic billboard_config_bit0_pin_out,
    input wire logic billboard_config_bit0_pin_oe,
    input wire logic billboard_config_bit1_pin_out,
    input wire logic billboard_config_bit1_pin_oe,
    output logic bus_mode_strap_in,
    output logic power_control_polarity_strap,
    output logic billboard_enable_pin_in,
    output logic billboard_config_bit0_pin_in,
    output logic billboard_config_bit1_pin_in
);
    // wire level: block drive wins over resistor
    assign bus_mode_strap_in = bus_mode_strap_oe ? bus_mode_strap_out : straps.bus_mode;
    assign power_control_polarity_strap = straps.polarity;
    assign billboard_enable_pin_in = billboard_enable_pin_oe ?
        billboard_enable_pin_out : straps.bb_en;
    assign billboard_config_bit0_pin_in = billboard_config_bit0_pin_oe ?
        billboard_config_bit0_pin_out : straps.cfg0;
    assign billboard_config_bit1_pin_in = billboard_config_bit1_pin_oe ?
        billboard_config_bit1_pin_out : straps.cfg1;
endmodule

// ---- tb/tb_top.sv ----
/* bench: boots the block under three strap sets, checks latched
   config, indicators and host overrides. assumes the board model. */
`timescale 1ns/10ps
module tb_top;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    ssp_pkg::ssp_straps_t straps = 5'h17;
    logic status_output_enable = 1'b0, charging_enabled = 1'b0, reg_billboard_enable = 1'b0;
    logic [3:0] port_power_on = 4'h5;
    ssp_pkg::ssp_link_t link_status = 4'h0;
    logic [1:0] reg_billboard_configured = 2'h0;
    ssp_pkg::ssp_host_wr_t host_wr = 8'h00;
    int n_errors = 0;
    int num_checks = 0;
    logic bus_mode_strap_in, bus_mode_strap_out, bus_mode_strap_oe, power_control_polarity_strap;
    logic billboard_enable_pin_in, billboard_enable_pin_out, billboard_enable_pin_oe;
    logic billboard_config_bit0_pin_in, billboard_config_bit0_pin_out;
    logic billboard_config_bit0_pin_oe;
    logic billboard_config_bit1_pin_in, billboard_config_bit1_pin_out;
    logic billboard_config_bit1_pin_oe;
    logic [3:0] port_power_control_outputs;
    logic [1:0] billboard_configured_field;
    logic smbus_target_mode, billboard_present, grouped_power;
    logic full_auto_charge_enable, power_switch_unsupported, auto_charge_mode_bit;
    ssp_strap_status ssp_strap_status_inst (.*);
    ssp_board_model ssp_board_model_inst (.*);
    always #2 ref_clk = ~ref_clk;
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
        num_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("[FAIL] %s expected %h seen %h", nm, exp, got);
        end
    endtask
    task automatic boot(input ssp_pkg::ssp_straps_t s, input logic c);
        straps <= s;
        charging_enabled <= c;
        status_output_enable <= 1'b0;
        srst <= 1'b1;
        cyc(20);
        srst <= 1'b0;
        cyc(4);
    endtask
    task automatic wr(input ssp_pkg::ssp_host_wr_t w);
        host_wr <= w;
        cyc(1);
    endtask
    task automatic end_sim;
        if (n_errors == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    initial begin
        #100000;
        n_errors++;
        end_sim();
    end
    // ------------------------------------------------------------
    // main sequence
    // ------------------------------------------------------------
    initial begin
        // i2c, active high power, billboard on, config 2
        boot(5'h17, 1'b0);
        chk("smbus", 8'h00, smbus_target_mode);
        chk("pwr", 8'h05, port_power_control_outputs);
        chk("bb", 8'h01, billboard_present);
        chk("cfg", 8'h02, billboard_configured_field);
        // straps change after latch, host write refused
        status_output_enable <= 1'b1;
        link_status <= 4'h8;
        straps <= 5'h00;
        wr(8'hC0);
        host_wr <= 8'h00;
        cyc(6);
        chk("ss_out", 8'h01, bus_mode_strap_out);
        chk("bb_oe", 8'h00, billboard_enable_pin_oe);
        chk("grp", 8'h00, grouped_power);
        chk("bb", 8'h00, billboard_present);
        chk("cfg", 8'h00, billboard_configured_field);
        link_status <= 4'h0;
        cyc(6);
        chk("smbus", 8'h00, smbus_target_mode);
        chk("pwr", 8'h05, port_power_control_outputs);
        // smbus, active low, grouped, charging on
        boot(5'h1C, 1'b1);
        chk("smbus", 8'h01, smbus_target_mode);
        chk("pwr", 8'h0A, port_power_control_outputs);
        chk("grp", 8'h01, grouped_power);
        chk("full", 8'h01, full_auto_charge_enable);
        chk("auto", 8'h01, auto_charge_mode_bit);
        chk("bb", 8'h00, billboard_present);
        chk("cfg", 8'h00, billboard_configured_field);
        wr(8'h80);
        wr(8'h20);
        wr(8'h02);
        host_wr <= 8'h00;
        cyc(2);
        chk("wr", 8'h00, {grouped_power, full_auto_charge_enable, auto_charge_mode_bit});
        status_output_enable <= 1'b1;
        for (int i = 0; i < 2; i++) begin
            link_status <= i ? 4'hA : 4'h5;
            cyc(4);
            chk("oe", 8'h0F, {bus_mode_strap_oe, billboard_enable_pin_oe,
                billboard_config_bit0_pin_oe, billboard_config_bit1_pin_oe});
            chk("ind", {4'h0, link_status.ss_suspend, link_status.hs_connect,
                link_status.ss_connect, link_status.high_speed_suspend_indicator},
                {bus_mode_strap_out, billboard_enable_pin_out,
                billboard_config_bit0_pin_out, billboard_config_bit1_pin_out});
        end
        // smbus, charging off, switch unsupported
        boot(5'h0A, 1'b0);
        chk("nosw", 8'h01, power_switch_unsupported);
        chk("st", 8'h00, {grouped_power, full_auto_charge_enable, auto_charge_mode_bit});
        reg_billboard_enable <= 1'b1;
        reg_billboard_configured <= 2'h2;
        port_power_on <= 4'hA;
        wr(8'h08);
        wr(8'hC0);
        host_wr <= 8'h00;
        cyc(4);
        chk("bb", 8'h01, billboard_present);
        chk("cfg", 8'h02, billboard_configured_field);
        chk("nosw", 8'h00, power_switch_unsupported);
        chk("grp", 8'h01, grouped_power);
        chk("pwr", 8'h0A, port_power_control_outputs);
        end_sim();
    end
endmodule
